// *** include/lgs_pkg.sv ***
// Constants shared by the gate-input selection block
package lgs_pkg;

    // ************************************************************
    // Register bus geometry
    // ************************************************************
    localparam int unsigned LGS_ADDR_W = 4;
    localparam int unsigned LGS_DATA_W = 8;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [3:0] LGS_OFS_SEL_A   = 4'h0; // Channel 1 and 2 source select
    localparam logic [3:0] LGS_OFS_SEL_B   = 4'h1; // Channel 3 and 4 source select
    localparam logic [3:0] LGS_OFS_G1_EN   = 4'h2; // Gate one term enables
    localparam logic [3:0] LGS_OFS_G2_EN   = 4'h3; // Gate two term enables

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam logic [7:0] LGS_SEL_MASK    = 8'h77; // Bits 7 and 3 unimplemented
    localparam logic [7:0] LGS_EN_MASK     = 8'hff; // All enable bits implemented
    localparam logic [7:0] LGS_RST_VAL     = 8'h00; // Defined value after reset
    localparam int unsigned LGS_LO_FLD     = 0;     // Low select field position
    localparam int unsigned LGS_HI_FLD     = 4;     // High select field position
    localparam int unsigned LGS_SEL_W      = 3;     // Width of one select field

    // ************************************************************
    // Channel and input counts
    // ************************************************************
    localparam int unsigned LGS_NUM_CH     = 4;     // Data channels per gate
    localparam int unsigned LGS_NUM_IN     = 16;    // Numbered cell inputs
    localparam int unsigned LGS_CH_STEP    = 4;     // Input offset between channels
    localparam int unsigned LGS_TERM_W     = 8;     // Enable bits per gate

endpackage

// *** include/lgs_gate_if.sv ***
// Carrier between the top and one gate: channels, enables, gate result
`timescale 1ns/100ps
interface lgs_gate_if;
    logic [3:0] chan;  // Selected data channels 4..1
    logic [7:0] en;    // Term enables, odd bits true form, even bits inverted
    logic       gate;  // Combined gate level

    modport top  (output chan, output en, input gate);
    modport gate_side (input chan, input en, output gate);
endinterface

// *** hdl/lgs_gate.sv ***
// One gate: OR of enabled true and inverted channel terms
`timescale 1ns/100ps
module lgs_gate (
    lgs_gate_if.gate_side gif   // Channels in, gate level out
);

    // ************************************************************
    // Per-channel term selection
    // ************************************************************
    wire [3:0] term;

    // Bit 2k+1 passes channel k true, bit 2k passes it inverted
    genvar k;
    generate
        for (k = 0; k < lgs_pkg::LGS_NUM_CH; k++) begin : g_term
            assign term[k] = (gif.en[2*k+1] & gif.chan[k])
                           | (gif.en[2*k] & ~gif.chan[k]);
        end
    endgenerate

    // No enabled term leaves the gate at its inactive low level
    assign gif.gate = |term;

endmodule // lgs_gate

// *** hdl/lgs_top.sv ***
// Gate-input selection for gates one and two of a logic cell
// How it works
// - Gate one odd bits pass true channels
// - Gate one even bits pass inverted channels
// - Gate two uses the same enable layout
// - Eight-bit read-write enable registers, retained; select registers keep six bits, bits 7 and 3 read zero
// - Three-bit fields pick each channel's input
`timescale 1ns/100ps
module lgs_top (
    input  wire logic        clk,          // 125 MHz clock
    input  wire logic        rst,          // Asynchronous reset, active high
    input  wire logic [3:0]  reg_addr,     // Register offset
    input  wire logic [7:0]  reg_wdata,    // Write data
    input  wire logic        reg_wr,       // Write strobe
    input  wire logic        reg_rd,       // Read strobe
    output logic      [7:0]  reg_rdata,    // Read data, cycle after strobe
    input  wire logic [15:0] cell_in,      // Numbered cell input signals
    output logic             gate_one_out, // Gate one level
    output logic             gate_two_out  // Gate two level
);

    // ************************************************************
    // Register bus decode
    // ************************************************************
    logic [7:0] sel_a_ff;
    logic [7:0] sel_b_ff;
    logic [7:0] g1_en_ff;
    logic [7:0] g2_en_ff;
    logic [7:0] rdata_ff;

    wire hit_sel_a = reg_addr == lgs_pkg::LGS_OFS_SEL_A;
    wire hit_sel_b = reg_addr == lgs_pkg::LGS_OFS_SEL_B;
    wire hit_g1    = reg_addr == lgs_pkg::LGS_OFS_G1_EN;
    wire hit_g2    = reg_addr == lgs_pkg::LGS_OFS_G2_EN;

    // Read selection; unmapped offsets and idle cycles give zero
    wire [7:0] nxt_rdata = !reg_rd   ? lgs_pkg::LGS_RST_VAL
                         : hit_sel_a ? sel_a_ff
                         : hit_sel_b ? sel_b_ff
                         : hit_g1    ? g1_en_ff
                         : hit_g2    ? g2_en_ff
                         : lgs_pkg::LGS_RST_VAL;

    // Write data with unimplemented select bits forced low
    wire [7:0] nxt_sel = reg_wdata & lgs_pkg::LGS_SEL_MASK;
    wire [7:0] nxt_en  = reg_wdata & lgs_pkg::LGS_EN_MASK;

    // ************************************************************
    // Software registers
    // ************************************************************
    // Registers change only on reset or a write strobe, so nothing else disturbs them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_a_ff <= lgs_pkg::LGS_RST_VAL;
            sel_b_ff <= lgs_pkg::LGS_RST_VAL;
            g1_en_ff <= lgs_pkg::LGS_RST_VAL;
            g2_en_ff <= lgs_pkg::LGS_RST_VAL;
        end else if (reg_wr) begin
            if (hit_sel_a) sel_a_ff <= nxt_sel;
            if (hit_sel_b) sel_b_ff <= nxt_sel;
            if (hit_g1)    g1_en_ff <= nxt_en;
            if (hit_g2)    g2_en_ff <= nxt_en;
        end
    end

    // Read data register, valid only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= lgs_pkg::LGS_RST_VAL;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [15:0] in_meta_ff;
    logic [15:0] in_sync_ff;

    // Two flops before any logic sees the cell inputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_meta_ff <= '0;
            in_sync_ff <= '0;
        end else begin
            in_meta_ff <= cell_in;
            in_sync_ff <= in_meta_ff;
        end
    end

    // ************************************************************
    // Channel source multiplexers
    // ************************************************************
    wire [2:0] ch_sel [4];

    // Channels 1 and 2 from the first select register, 3 and 4 from the second
    assign ch_sel[0] = sel_a_ff[lgs_pkg::LGS_LO_FLD +: lgs_pkg::LGS_SEL_W];
    assign ch_sel[1] = sel_a_ff[lgs_pkg::LGS_HI_FLD +: lgs_pkg::LGS_SEL_W];
    assign ch_sel[2] = sel_b_ff[lgs_pkg::LGS_LO_FLD +: lgs_pkg::LGS_SEL_W];
    assign ch_sel[3] = sel_b_ff[lgs_pkg::LGS_HI_FLD +: lgs_pkg::LGS_SEL_W];

    wire [3:0] chan;

    // Channel k starts at input 4k and wraps modulo the input count
    genvar k;
    generate
        for (k = 0; k < lgs_pkg::LGS_NUM_CH; k++) begin : g_chan
            wire [3:0] idx = 4'(k * lgs_pkg::LGS_CH_STEP) + {1'b0, ch_sel[k]};
            assign chan[k] = in_sync_ff[idx];
        end
    endgenerate

    // ************************************************************
    // Gates one and two
    // ************************************************************
    lgs_gate_if g1_if ();
    lgs_gate_if g2_if ();

    // Both gates see the same channels, each with its own enable set
    assign g1_if.chan = chan;
    assign g1_if.en   = g1_en_ff;
    assign g2_if.chan = chan;
    assign g2_if.en   = g2_en_ff;

    lgs_gate u_gate_one (
        .gif (g1_if.gate_side)
    );

    lgs_gate u_gate_two (
        .gif (g2_if.gate_side)
    );

    logic g1_out_ff;
    logic g2_out_ff;

    // Registered gate levels toward the combining stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            g1_out_ff <= 1'b0;
            g2_out_ff <= 1'b0;
        end else begin
            g1_out_ff <= g1_if.gate;
            g2_out_ff <= g2_if.gate;
        end
    end

    assign gate_one_out = g1_out_ff;
    assign gate_two_out = g2_out_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Gate one true term of channel 4 drives the gate high
    a_g1_true_term: assert property (
        (g1_en_ff[7] && chan[3]) |=> gate_one_out
    ) else $error("gate one ignores enabled true term");

    // Gate one inverted term of channel 1 drives the gate high
    a_g1_inv_term: assert property (
        (g1_en_ff[0] && !chan[0]) |=> gate_one_out
    ) else $error("gate one ignores enabled inverted term");

    // Gate two with only a true enable follows that channel
    a_g2_true_only: assert property (
        (g2_en_ff == 8'h20) |=> (gate_two_out == $past(chan[2]))
    ) else $error("gate two true term wrong");

    // Gate two with only an inverted enable follows the inverse
    a_g2_inv_only: assert property (
        (g2_en_ff == 8'h10) |=> (gate_two_out == !$past(chan[2]))
    ) else $error("gate two inverted term wrong");

    // Written enables are stored and read back intact
    a_en_write_read: assert property (
        (reg_wr && hit_g1) ##1 (reg_rd && hit_g1 && !reg_wr)
            |=> (reg_rdata == $past(reg_wdata, 2))
    ) else $error("gate one enables not read back");

    // Enables hold without a write to them
    a_en_retained: assert property (
        !(reg_wr && hit_g2) |=> $stable(g2_en_ff)
    ) else $error("gate two enables changed without write");

    // Select field value 4 on channel 4 picks input 0
    a_ch4_wrap: assert property (
        (sel_b_ff[6:4] == 3'h4) |-> (chan[3] == in_sync_ff[0])
    ) else $error("channel 4 source wrong");

    // Select field value 7 on channel 1 picks input 7
    a_ch1_top: assert property (
        (sel_a_ff[2:0] == 3'h7) |-> (chan[0] == in_sync_ff[7])
    ) else $error("channel 1 source wrong");

    // A gate with no enables stays low
    a_gate_idle_low: assert property (
        (g1_en_ff == 8'h00) [*2] |-> !gate_one_out
    ) else $error("idle gate one not low");

endmodule // lgs_top

// *** tb/lgs_top_tb_top.sv ***
// Self-checking bench for the gate-input selection block
`timescale 1ns/100ps
module lgs_top_tb_top;
    logic        clk        = 1'b0;
    logic        rst        = 1'b1;
    logic [3:0]  reg_addr   = 4'h0;
    logic [7:0]  reg_wdata  = 8'h00;
    logic        reg_wr     = 1'b0;
    logic        reg_rd     = 1'b0;
    logic [7:0]  reg_rdata;
    logic [15:0] cell_in    = 16'h0000;
    logic        gate_one_out;
    logic        gate_two_out;
    logic        rd_d       = 1'b0;  // Read strobe of the previous cycle
    logic        gchk       = 1'b0;  // Gate sample request
    logic [7:0]  rd_q[$];
    logic [1:0]  gate_q[$];
    logic [1:0]  g_exp;                               // Oldest gate expectation
    logic [7:0]  sh[4]      = '{default: 8'h00};  // Shadow of the four registers
    logic [31:0] rnd        = 32'h73a6_962a;
    int          fails      = 0;
    int          n_compared = 0;

    always #4 clk = ~clk;

    lgs_top lgs_top_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cell_in(cell_in), .gate_one_out(gate_one_out),
        .gate_two_out(gate_two_out));

    // ************************************************************
    // Helpers: random source, expectations, bus cycles
    // ************************************************************
    function automatic logic [31:0] lfsr(logic [31:0] x);
        for (int i = 0; i < 8; i++) begin
            x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
        end
        return x;
    endfunction

    // OR of enabled true and inverted channel terms
    function automatic logic exp_gate(logic [7:0] en);
        logic [3:0] ch;
        logic       g;
        g = 1'b0;
        for (int k = 0; k < 4; k++) begin
            ch[k] = cell_in[(4 * k + int'((k % 2) ? sh[k / 2][6:4] : sh[k / 2][2:0])) % 16];
            g = g | (en[2 * k + 1] & ch[k]) | (en[2 * k] & ~ch[k]);
        end
        return g;
    endfunction

    task automatic check(logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(logic wr, logic rd, logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        reg_wr    <= wr;
        reg_rd    <= rd;
        reg_addr  <= a;
        reg_wdata <= d;
    endtask

    // Unmapped offsets leave the shadow untouched
    task automatic wr_reg(logic [3:0] a, logic [7:0] d);
        if (a < 4'h4) begin
            sh[a[1:0]] = d & ((a < 4'h2) ? lgs_pkg::LGS_SEL_MASK : lgs_pkg::LGS_EN_MASK);
        end
        bus(1'b1, 1'b0, a, d);
    endtask

    task automatic rd_reg(logic [3:0] a);
        rd_q.push_back((a < 4'h4) ? sh[a[1:0]] : 8'h00);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask

    // Drop strobes, new inputs, let them pass the synchronisers, then sample both gates
    task automatic gate_check(logic [15:0] v);
        bus(1'b0, 1'b0, 4'h0, 8'h00);
        cell_in <= v;
        repeat (5) bus(1'b0, 1'b0, 4'h0, 8'h00);
        gate_q.push_back({exp_gate(sh[2]), exp_gate(sh[3])});
        @(posedge clk) gchk <= 1'b1;
        @(posedge clk) gchk <= 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ************************************************************
    // Monitor and watchdog
    // ************************************************************
    always @(posedge clk) begin
        if (!rst) begin  // Outputs are unknown until the first reset edge
            check(reg_rdata, rd_d ? rd_q.pop_front() : 8'h00);
            if (gchk) begin
                g_exp = gate_q.pop_front();
                check({6'h00, gate_one_out, gate_two_out}, {6'h00, g_exp});
            end
        end
        rd_d <= reg_rd;
    end

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        tally_and_finish();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Reset values, unmapped offsets, idle gates
        for (int a = 0; a < 16; a++) rd_reg(4'(a));
        gate_check(16'hffff);
        // All ones everywhere, back-to-back, then read back
        for (int a = 0; a < 16; a++) wr_reg(4'(a), 8'hff);
        for (int a = 0; a < 16; a++) rd_reg(4'(a));
        // One enable bit at a time, inputs plain and inverted
        for (int g = 2; g < 4; g++) begin
            for (int b = 0; b < 8; b++) begin
                rnd = lfsr(rnd);
                wr_reg(4'(g), 8'h01 << b);
                rd_reg(4'(g));
                wr_reg(4'(5 - g), 8'h00);
                wr_reg(4'h0, rnd[7:0]);
                wr_reg(4'h1, rnd[15:8]);
                gate_check(rnd[31:16]);
                gate_check(~rnd[31:16]);
            end
        end
        // Random selects, enables and inputs
        for (int i = 0; i < 40; i++) begin
            for (int a = 0; a < 4; a++) begin
                rnd = lfsr(rnd);
                wr_reg(4'(a), rnd[7:0]);
            end
            rd_reg(rnd[11:8]);
            gate_check(rnd[31:16]);
        end
        // Reset in mid-run clears every register
        repeat (3) bus(1'b0, 1'b0, 4'h0, 8'h00);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        sh = '{default: 8'h00};
        for (int a = 0; a < 4; a++) rd_reg(4'(a));
        gate_check(16'h5a5a);
        repeat (3) bus(1'b0, 1'b0, 4'h0, 8'h00);
        tally_and_finish();
    end
endmodule // lgs_top_tb_top
